// ===== rtl/dio_pin_sync.sv
// Three-stage pin input synchroniser with agreement filter.
// Assumes raw pin levels are asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module dio_pin_sync
    import dio_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    dio_sync_if.sync pins // Raw in, filtered out
);
    logic [63:0] s1_reg;
    logic [63:0] s2_reg;
    logic [63:0] s3_reg;
    logic [63:0] stable_reg;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pins.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable_reg <= '0;
        end else begin
            stable_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stable_reg);
        end
    end

    assign pins.stable = stable_reg;
endmodule : dio_pin_sync
`default_nettype wire

// ===== rtl/dio_pkg.sv
// Constants shared by the digital port block: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
package dio_pkg;
    localparam int DIO_ADDR_W = 14;
    localparam int DIO_NPORT = 16;
    localparam int DIO_NPIN = 64;
    // Printed data-memory addresses are register indices; byte address is index * 4
    localparam logic [11:0] DIO_IDX_PULLUP = 12'hfe0;
    localparam logic [11:0] DIO_IDX_BITOP = 12'hfe4;
    localparam logic [11:0] DIO_IDX_DIR_A = 12'hfe8;
    localparam logic [11:0] DIO_IDX_DIR_B = 12'hfec;
    localparam logic [11:0] DIO_IDX_PORT0 = 12'hff0;
    // Bit operation command fields
    localparam int DIO_BOP_PORT_LSB = 0;
    localparam int DIO_BOP_BIT_LSB = 4;
    localparam int DIO_BOP_OP_LSB = 6;
    localparam int DIO_BOP_VAL_POS = 8;
    localparam logic [1:0] DIO_OP_NONE = 2'h0;
    localparam logic [1:0] DIO_OP_SET = 2'h1;
    localparam logic [1:0] DIO_OP_CLEAR = 2'h2;
    localparam logic [1:0] DIO_OP_MOVE = 2'h3;
    // Writable bits: pull-ups on ports 0..3 and 6, whole-port modes on 2,4,5,7
    localparam logic [7:0] DIO_PULLUP_MASK = 8'h4f;
    localparam logic [7:0] DIO_DIR_B_MASK = 8'hb4;
    localparam logic [7:0] DIO_DIR_RESET = 8'h00;
    localparam logic [7:0] DIO_PULLUP_RESET = 8'h00;
    localparam logic [63:0] DIO_LATCH_RESET = 64'h0;
    localparam logic [1:0] DIO_RESP_OKAY = 2'h0;
    localparam logic [1:0] DIO_RESP_SLVERR = 2'h2;
endpackage : dio_pkg

// ===== rtl/dio_port_ctrl.sv
// Memory-mapped 4-bit digital I/O ports with direction and pull-up control.
// Assumes an AXI4-Lite master on aclk and asynchronous external pin levels.
`timescale 1ns/100ps
`default_nettype none
module dio_port_ctrl
    import dio_pkg::*;
(
    input wire logic aclk, // System clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [13:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [13:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [63:0] pin_in, // Pin levels, port n pin k at 4n+k
    output logic [63:0] pin_out, // Output latch levels
    output logic [63:0] pin_oe, // Output buffer enable, high drives
    output logic [63:0] pin_pullup_en // Internal pull-up connect
);
    dio_sync_if sync_bus ();

    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [11:0] wr_idx_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [11:0] rd_idx_reg;
    logic [7:0] dir_reg_a;
    logic [7:0] dir_reg_b;
    logic [7:0] pullup_enable_reg;
    logic [63:0] latch_reg;
    logic [63:0] oe_reg;
    logic [63:0] pullup_pin_reg;
    logic [63:0] mode_vec;
    logic [63:0] pullup_vec;
    logic [63:0] port_rd_vec;
    logic wr_do;
    logic rd_do;
    logic wr_hit_port;
    logic rd_hit_port;
    logic [3:0] wr_port;
    logic [3:0] rd_port;
    logic [3:0] bop_port;
    logic [1:0] bop_bit;
    logic [1:0] bop_op;
    logic [3:0] bop_result;
    logic wr_mapped;
    logic rd_mapped;
    logic [31:0] rd_value;

    assign sync_bus.raw = pin_in;

    dio_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(sync_bus)
    );

    // Mode and pull-up slices for every port; per-pin modes only on ports 3 and 6, pull-ups whole-port on ports 0..3 and 6 except pin 0 of port 0 (none)
    genvar gp;
    generate
        for (gp = 0; gp < DIO_NPORT; gp++) begin : g_port
            if (gp == 3) begin : g_p3
                assign mode_vec[gp*4 +: 4] = dir_reg_a[3:0];
            end else if (gp == 6) begin : g_p6
                assign mode_vec[gp*4 +: 4] = dir_reg_a[7:4];
            end else if (gp == 2 || gp == 4 || gp == 5 || gp == 7) begin : g_pw
                assign mode_vec[gp*4 +: 4] = {4{dir_reg_b[gp]}};
            end else begin : g_pin
                // No mode bit for these ports here; they stay inputs
                assign mode_vec[gp*4 +: 4] = 4'h0;
            end
            if (gp == 0) begin : g_pu0
                assign pullup_vec[gp*4 +: 4] = {{3{pullup_enable_reg[gp]}}, 1'b0};
            end else if (gp < 8) begin : g_pu
                assign pullup_vec[gp*4 +: 4] = {4{pullup_enable_reg[gp]}};
            end else begin : g_punone
                assign pullup_vec[gp*4 +: 4] = 4'h0;
            end
            // Output bits read back the latch, input bits the pin
            assign port_rd_vec[gp*4 +: 4] = (mode_vec[gp*4 +: 4] & latch_reg[gp*4 +: 4])
                | (~mode_vec[gp*4 +: 4] & sync_bus.stable[gp*4 +: 4]);
        end
    endgenerate

    // Address decode
    assign wr_hit_port = (wr_idx_reg[11:4] == DIO_IDX_PORT0[11:4]);
    assign rd_hit_port = (rd_idx_reg[11:4] == DIO_IDX_PORT0[11:4]);
    assign wr_port = wr_idx_reg[3:0];
    assign rd_port = rd_idx_reg[3:0];
    assign wr_mapped = wr_hit_port || wr_idx_reg == DIO_IDX_PULLUP || wr_idx_reg == DIO_IDX_BITOP
        || wr_idx_reg == DIO_IDX_DIR_A || wr_idx_reg == DIO_IDX_DIR_B;
    assign rd_mapped = rd_hit_port || rd_idx_reg == DIO_IDX_PULLUP || rd_idx_reg == DIO_IDX_BITOP
        || rd_idx_reg == DIO_IDX_DIR_A || rd_idx_reg == DIO_IDX_DIR_B;
    assign wr_do = !awready_reg && !wready_reg && !bvalid_reg;
    assign rd_do = !arready_reg && !rvalid_reg;

    // Single-bit command fields
    assign bop_port = wdata_reg[DIO_BOP_PORT_LSB +: 4];
    assign bop_bit = wdata_reg[DIO_BOP_BIT_LSB +: 2];
    assign bop_op = wdata_reg[DIO_BOP_OP_LSB +: 2];

    // Read-modify-write from the port's read value: input bits pick up
    // the pins, which is why the latch is unpredictable in input mode
    always_comb begin
        bop_result = port_rd_vec[bop_port*4 +: 4];
        unique case (bop_op)
            DIO_OP_SET: bop_result[bop_bit] = 1'b1;
            DIO_OP_CLEAR: bop_result[bop_bit] = 1'b0;
            DIO_OP_MOVE: bop_result[bop_bit] = wdata_reg[DIO_BOP_VAL_POS];
            DIO_OP_NONE: bop_result = port_rd_vec[bop_port*4 +: 4];
        endcase
    end

    always_comb begin
        rd_value = 32'h0;
        if (rd_hit_port) begin
            rd_value[3:0] = port_rd_vec[rd_port*4 +: 4];
            // Even port also shows its odd partner for byte reads
            if (!rd_port[0]) begin
                rd_value[7:4] = port_rd_vec[rd_port*4 + 4 +: 4];
            end
        end else if (rd_idx_reg == DIO_IDX_DIR_A) begin
            rd_value[7:0] = dir_reg_a;
        end else if (rd_idx_reg == DIO_IDX_DIR_B) begin
            rd_value[7:0] = dir_reg_b;
        end else if (rd_idx_reg == DIO_IDX_PULLUP) begin
            rd_value[7:0] = pullup_enable_reg;
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wr_idx_reg <= 12'h0;
        end else if (s_axi_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            wr_idx_reg <= s_axi_awaddr[13:2];
        end else if (bvalid_reg && s_axi_bready) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg <= 1'b1;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (bvalid_reg && s_axi_bready) begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= DIO_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? DIO_RESP_OKAY : DIO_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Direction registers; whole-byte writes expected from software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_reg_a <= DIO_DIR_RESET;
            dir_reg_b <= DIO_DIR_RESET;
        end else if (wr_do && wstrb_reg[0]) begin
            if (wr_idx_reg == DIO_IDX_DIR_A) begin
                dir_reg_a <= wdata_reg[7:0];
            end
            if (wr_idx_reg == DIO_IDX_DIR_B) begin
                dir_reg_b <= wdata_reg[7:0] & DIO_DIR_B_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pullup_enable_reg <= DIO_PULLUP_RESET;
        end else if (wr_do && wstrb_reg[0] && wr_idx_reg == DIO_IDX_PULLUP) begin
            pullup_enable_reg <= wdata_reg[7:0] & DIO_PULLUP_MASK;
        end
    end

    // Output latches: written in either mode; the mode only gates the buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_reg <= DIO_LATCH_RESET;
        end else if (wr_do && wstrb_reg[0]) begin
            if (wr_hit_port) begin
                latch_reg[wr_port*4 +: 4] <= wdata_reg[3:0];
            end else if (wr_idx_reg == DIO_IDX_BITOP && bop_op != DIO_OP_NONE) begin
                latch_reg[bop_port*4 +: 4] <= bop_result;
            end
        end
    end

    // Pin-facing outputs registered; one cycle behind the mode and pull-up registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_reg <= 64'h0;
            pullup_pin_reg <= 64'h0;
        end else begin
            oe_reg <= mode_vec;
            pullup_pin_reg <= pullup_vec;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rd_idx_reg <= 12'h0;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rd_idx_reg <= s_axi_araddr[13:2];
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= DIO_RESP_OKAY;
            rdata_reg <= 32'h0;
        end else if (rd_do) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_mapped ? DIO_RESP_OKAY : DIO_RESP_SLVERR;
            rdata_reg <= rd_value;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign pin_out = latch_reg;
    assign pin_oe = oe_reg;
    assign pin_pullup_en = pullup_pin_reg;
endmodule : dio_port_ctrl
`default_nettype wire

// ===== rtl/dio_sync_if.sv
// Carrier between the port block and its pin input synchroniser.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface dio_sync_if;
    logic [63:0] raw;
    logic [63:0] stable;
    modport sync (input raw, output stable);
    modport user (output raw, input stable);
endinterface : dio_sync_if
`default_nettype wire

// ===== tb/dio_pin_model.sv
// Behavioural model of the circuitry on the port pins.
// Assumes the bench chooses which pins it drives; others float or pull up.
`timescale 1ns/100ps
`default_nettype none
module dio_pin_model (
    input wire logic aclk, // Clock
    input wire logic [63:0] pin_out, // Latches
    input wire logic [63:0] pin_oe, // Buffers on
    input wire logic [63:0] pin_pullup_en, // Pull-ups
    input wire logic [63:0] ext_val, // External level
    input wire logic [63:0] ext_en, // External drive on
    output logic [63:0] pin_level // Wire level
);
    logic [63:0] float_reg = 64'h5555_5555_5555_5555;
    // A floating pin must not settle to a lucky constant
    always_ff @(posedge aclk) float_reg <= ~float_reg;
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pin_pullup_en)
        | (~pin_oe & ~ext_en & ~pin_pullup_en & float_reg);
endmodule : dio_pin_model
`default_nettype wire

// ===== tb/dio_port_ctrl_bench.sv
// Bench for the digital port block: AXI4-Lite tasks and port scenarios.
// Assumes the pin model on the pins and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module dio_port_ctrl_bench
    import dio_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [63:0] pin_in, pin_out, pin_oe, pin_pullup_en, ext_val, ext_en;
    logic [31:0] bop [5] = '{32'h054, 32'h084, 32'h1f4, 32'h0e4, 32'h014};
    logic [3:0] bexp [5] = '{4'h7, 4'h6, 4'he, 4'ha, 4'ha};
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    dio_port_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
        .pin_out, .pin_oe, .pin_pullup_en);
    dio_pin_model pins_u (.aclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_val, .ext_en, .pin_level(pin_in));
    task automatic close_out;
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [13:0] ba(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction : ba
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(64'(s_axi_bresp), 64'(er));
    endtask : wr
    task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(64'(s_axi_rresp), 64'(er));
        chk(64'(s_axi_rdata & m), 64'(ed & m));
    endtask : rd
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        ext_val = 64'h0123_4567_89ab_cdef;
        ext_en = '1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ba(DIO_IDX_DIR_A), 32'h0, 32'hff, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_DIR_B), 32'h0, 32'hff, DIO_RESP_OKAY);
        chk(pin_oe, 64'h0);
        for (int n = 0; n < 16; n++) begin
            rd(ba(DIO_IDX_PORT0 + 12'(n)), 32'(ext_val >> (4*n)), n[0] ? 32'hf : 32'hff, DIO_RESP_OKAY);
        end
        wr(ba(DIO_IDX_PORT0 + 12'd3), 32'h3, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_PORT0 + 12'd3), 32'hc, 32'hf, DIO_RESP_OKAY);
        chk(64'({pin_oe[15:12], pin_out[15:12]}), 64'h03);
        wr(ba(DIO_IDX_DIR_A), 32'h5a, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_DIR_A), 32'h5a, 32'hff, DIO_RESP_OKAY);
        // Low byte lane off: the mode byte must stay as it was
        s_axi_wstrb <= 4'he;
        wr(ba(DIO_IDX_DIR_A), 32'h00, DIO_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(ba(DIO_IDX_DIR_A), 32'h5a, 32'hff, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_PORT0 + 12'd3), 32'h6, 32'hf, DIO_RESP_OKAY);
        wr(ba(DIO_IDX_PORT0 + 12'd3), 32'h1, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_PORT0 + 12'd3), 32'h4, 32'hf, DIO_RESP_OKAY);
        wr(ba(DIO_IDX_DIR_B), 32'hff, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_DIR_B), 32'hb4, 32'hff, DIO_RESP_OKAY);
        wr(ba(DIO_IDX_PORT0 + 12'd4), 32'h5, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_PORT0 + 12'd4), 32'h05, 32'hff, DIO_RESP_OKAY);
        chk(64'(pin_oe[31:8]), 64'hf5ffaf);
        for (int i = 0; i < 5; i++) begin
            wr(ba(DIO_IDX_BITOP), bop[i], DIO_RESP_OKAY);
            chk(64'(pin_out[19:16]), 64'(bexp[i]));
        end
        // Bit op on input port 1: its buffer stays off, port 4's latch untouched
        wr(ba(DIO_IDX_BITOP), 32'h51, DIO_RESP_OKAY);
        chk(64'({pin_oe[7:4], pin_out[19:16]}), 64'h0a);
        wr(ba(DIO_IDX_PULLUP), 32'hff, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_PULLUP), 32'h4f, 32'hff, DIO_RESP_OKAY);
        chk(pin_pullup_en, 64'h0000_0000_0f00_fffe);
        ext_en <= ~64'h10;
        repeat (8) @(posedge aclk);
        rd(ba(DIO_IDX_PORT0 + 12'd1), 32'hf, 32'hf, DIO_RESP_OKAY);
        wr(ba(DIO_IDX_PULLUP), 32'h0, DIO_RESP_OKAY);
        ext_en <= '1;
        rd(ba(DIO_IDX_PULLUP), 32'h0, 32'hff, DIO_RESP_OKAY);
        chk(pin_pullup_en, 64'h0);
        wr(14'h0000, 32'hff, DIO_RESP_SLVERR);
        rd(14'h0004, 32'h0, 32'hffffffff, DIO_RESP_SLVERR);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ba(DIO_IDX_DIR_A), 32'h0, 32'hff, DIO_RESP_OKAY);
        rd(ba(DIO_IDX_DIR_B), 32'h0, 32'hff, DIO_RESP_OKAY);
        chk(pin_oe, 64'h0);
        close_out();
    end
endmodule : dio_port_ctrl_bench
`default_nettype wire

// ===== tb/dio_port_ctrl_monitor.sv
// Checker for the digital port block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dio_port_ctrl_monitor
    import dio_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic [13:0] s_axi_awaddr, // AW addr
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic [31:0] s_axi_wdata, // W data
    input wire logic [3:0] s_axi_wstrb, // W strobes
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B resp
    input wire logic s_axi_bvalid, // B valid
    input wire logic [13:0] s_axi_araddr, // AR addr
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic s_axi_rvalid, // R valid
    input wire logic [63:0] pin_out, // Latches
    input wire logic [63:0] pin_oe, // Buffers on
    input wire logic [63:0] pin_pullup_en // Pull-ups
);
    logic [11:0] wa_reg;
    logic [11:0] ra_reg;
    logic [8:0] wd_reg;
    logic wr_port;
    logic wr_map;
    // Address and data may be taken on different edges
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr[13:2];
        if (s_axi_wvalid && s_axi_wready) wd_reg <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
        if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr[13:2];
    end
    assign wr_port = wa_reg[11:4] == 8'hff;
    assign wr_map = wr_port || (wa_reg inside {DIO_IDX_PULLUP, DIO_IDX_BITOP, DIO_IDX_DIR_A, DIO_IDX_DIR_B});
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_clear: assert property ($rose(aresetn) |-> pin_oe == '0 && pin_pullup_en == '0)
        else $error("outputs not cleared by reset");
    a_pullup_absent: assert property (pin_pullup_en[0] == 1'b0 && pin_pullup_en[23:16] == '0 && pin_pullup_en[63:28] == '0)
        else $error("pull-up on a pin without one");
    a_oe_fixed_in: assert property (pin_oe[7:0] == '0 && pin_oe[63:32] == '0)
        else $error("buffer on for an input-only port");
    a_oe_whole_port: assert property (pin_oe[11:8] inside {4'h0, 4'hf} && pin_oe[19:16] inside {4'h0, 4'hf}
        && pin_oe[23:20] inside {4'h0, 4'hf} && pin_oe[31:28] inside {4'h0, 4'hf})
        else $error("whole-port mode split");
    a_dir_a_oe: assert property ($rose(s_axi_bvalid) && wa_reg == DIO_IDX_DIR_A && wd_reg[8] |=>
        pin_oe[15:12] == wd_reg[3:0] && pin_oe[27:24] == wd_reg[7:4])
        else $error("per-pin modes not applied");
    a_pullup_follow: assert property ($rose(s_axi_bvalid) && wa_reg == DIO_IDX_PULLUP && wd_reg[8] |=>
        pin_pullup_en[3:1] == {3{wd_reg[0]}} && pin_pullup_en[7:4] == {4{wd_reg[1]}}
        && pin_pullup_en[27:24] == {4{wd_reg[6]}})
        else $error("pull-up enables not applied");
    a_port_latch: assert property ($rose(s_axi_bvalid) && wr_port && wd_reg[8] |->
        pin_out[4*wa_reg[3:0] +: 4] == wd_reg[3:0])
        else $error("port latch not loaded");
    a_read_out_bits: assert property ($rose(s_axi_rvalid) && ra_reg[11:4] == 8'hff |->
        ((s_axi_rdata[3:0] ^ pin_out[4*ra_reg[3:0] +: 4]) & pin_oe[4*ra_reg[3:0] +: 4]) == 4'h0)
        else $error("output bit read not from latch");
    a_write_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (wr_map ? DIO_RESP_OKAY : DIO_RESP_SLVERR))
        else $error("wrong write response");
    c_dir_write: cover property ($rose(s_axi_bvalid) && wa_reg == DIO_IDX_DIR_A);
    c_port_read: cover property ($rose(s_axi_rvalid) && ra_reg[11:4] == 8'hff);
    c_slave_err: cover property (s_axi_bvalid && s_axi_bresp == DIO_RESP_SLVERR);
endmodule : dio_port_ctrl_monitor
bind dio_port_ctrl dio_port_ctrl_monitor mon_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pin_out, .pin_oe, .pin_pullup_en);
`default_nettype wire
